// ---- hw/l2sc_ctrl.v ----
// Cache SRAM control and clock generator: select, write strobe, clocks,
// sync loop-back, sleep strobe, write data drive and byte parity.
// Assumes the core offers one access request at a time on ref_clk and
// holds it until accepted.
`timescale 1ns/10ps
`default_nettype none
`include "l2sc_defines.vh"

// Operation
// - Select low whenever the cache SRAMs are accessed, high otherwise.
// - Write strobe low only during cache writes.
// - Select and write strobe may change on any cache clock cycle.
// - Select and write strobe held high during hard reset.
// - Two cache clocks, identical and in phase by default.
// - Differential config makes second cache clock the inverse of first.
// - Both cache clocks held low during hard reset.
// - Sync clock output driven, low during hard reset.
// - Sync clock input, looped back, is timing alignment reference; here it only feeds syncLocked, which gates access.
// - Sleep strobe driven only when enabled by configuration; here it is always driven, held low while disabled.
// - Sleep strobe asserts on nap or sleep entry, negates on exit.
// - At least two cache clocks after sleep negation before access.
// - Sleep strobe held low during hard reset.
// - Data bus released one cycle when switching read and write; here the busy idle plus the turnaround idle release it two cache clocks.
// - Odd parity per write data byte lane.
module l2sc_ctrl
#(
    parameter LANES = 8
)
(
    input  wire                 ref_clk,
    input  wire                 arst_n,
    input  wire                 reqValid,
    input  wire                 reqWrite,
    input  wire [LANES*8-1:0]   reqData,
    output reg                  reqReady,
    input  wire                 cfgDiffClock,
    input  wire                 cfgSleepEnable,
    input  wire                 powerDown,
    input  wire                 cacheSyncClockIn,
    output reg                  cacheSramSelectN,
    output reg                  cacheSramWriteN,
    output reg                  cacheClockOutFirst,
    output reg                  cacheClockOutSecond,
    output reg                  cacheSyncClockOut,
    output reg                  sramSleepStrobe,
    output reg                  syncLocked,
    output reg  [LANES*8-1:0]   cacheDataOut,
    output reg  [LANES-1:0]     cacheByteParityOut,
    output reg                  cacheDataOe
);

    // ************************************************************
    // Cache clock generation
    // ************************************************************
    reg [3:0] divCnt_q;
    reg       cacheClk_q;
    wire      cacheClkRise = (divCnt_q == `L2SC_CLK_DIV_HALF) && !cacheClk_q;
    wire      cacheClkTick = (divCnt_q == `L2SC_CLK_DIV_HALF);

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divCnt_q   <= 4'h0;
            cacheClk_q <= 1'b0;
        end
        else if (cacheClkTick)
        begin
            divCnt_q   <= 4'h0;
            cacheClk_q <= !cacheClk_q;
        end
        else
            divCnt_q <= divCnt_q + 4'h1;
    end

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cacheClockOutFirst  <= 1'b0;
            cacheClockOutSecond <= 1'b0;
            cacheSyncClockOut   <= 1'b0;
        end
        else
        begin
            cacheClockOutFirst  <= cacheClk_q;
            cacheClockOutSecond <= cfgDiffClock ? !cacheClk_q
                                                : cacheClk_q;
            cacheSyncClockOut   <= cacheClk_q;
        end
    end

    // ************************************************************
    // Sync loop-back
    // ************************************************************
    // The returned clock is foreign to ref_clk, so it is synchronised.
    // Lock means its rising edges keep arriving; the access engine waits.
    reg       syncMeta_q;
    reg       syncSafe_q;
    reg       syncPrev_q;
    reg [3:0] syncAge_q;
    wire      syncRise = syncSafe_q && !syncPrev_q;
    // The age saturates, so a loop-back that stops leaves lock dropped
    // for good instead of wrapping round into a false lock.
    localparam [3:0] AGE_MAX     = `L2SC_SYNC_AGE_MAX;
    localparam [3:0] LOCK_WINDOW = `L2SC_LOCK_WINDOW;

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            syncMeta_q <= 1'b0;
            syncSafe_q <= 1'b0;
            syncPrev_q <= 1'b0;
            syncAge_q  <= AGE_MAX;
            syncLocked <= 1'b0;
        end
        else
        begin
            syncMeta_q <= cacheSyncClockIn;
            syncSafe_q <= syncMeta_q;
            syncPrev_q <= syncSafe_q;
            if (syncRise)
                syncAge_q <= 4'h0;
            else if (syncAge_q != AGE_MAX)
                syncAge_q <= syncAge_q + 4'h1;
            syncLocked <= (syncAge_q < LOCK_WINDOW);
        end
    end

    // ************************************************************
    // Access engine
    // ************************************************************
    // Requests are taken only on a cache clock rise, so select, strobe
    // and data stand a whole cache clock where the SRAMs sample them.
    // The busy flag forces an idle cache clock after each access; this
    // halves peak throughput but keeps select timing trivially legal.
    reg [1:0] lastOp_q;
    reg [3:0] gap_q;
    reg       busy_q;
    // A switch between read and write costs one idle cache clock, so the
    // SRAMs and this block never drive the data bus in the same cycle.
    wire      turnAround = (lastOp_q != `L2SC_OP_IDLE) &&
                           ((lastOp_q == `L2SC_OP_WRITE) != reqWrite);
    wire      canIssue = reqValid && !busy_q && syncLocked && !powerDown &&
                         !sramSleepStrobe && (gap_q == 4'h0) && !turnAround;

    // Reduction xnor gives one when a byte holds an even count of ones,
    // which is exactly the bit that makes the lane plus parity odd.
    function [LANES-1:0] oddPar;
        input [LANES*8-1:0] d;
        integer i;
        begin
            for (i = 0; i < LANES; i = i + 1)
                oddPar[i] = ~^d[i*8 +: 8];
        end
    endfunction

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cacheSramSelectN   <= 1'b1;
            cacheSramWriteN    <= 1'b1;
            sramSleepStrobe    <= 1'b0;
            cacheDataOut       <= {LANES*8{1'b0}};
            cacheByteParityOut <= {LANES{1'b0}};
            cacheDataOe        <= 1'b0;
            reqReady           <= 1'b0;
            lastOp_q           <= `L2SC_OP_IDLE;
            gap_q              <= 4'h0;
            busy_q             <= 1'b0;
        end
        else
        begin
            reqReady <= 1'b0;
            // Sleep strobe moves only on cache clock rising edges.
            if (cacheClkRise)
            begin
                // The wake gap is loaded on negation and counted only on
                // idle cache clock rises, so it can never be cut short.
                if (powerDown && cfgSleepEnable && !busy_q)
                    sramSleepStrobe <= 1'b1;
                else if (sramSleepStrobe)
                begin
                    sramSleepStrobe <= 1'b0;
                    gap_q <= `L2SC_WAKE_GAP;
                end
                else if (gap_q != 4'h0 && !busy_q)
                    gap_q <= gap_q - 4'h1;
            end
            // At most one access every two cache clocks; select and strobe change
            // only on cache clock rises.
            if (cacheClkRise)
            begin
                if (canIssue)
                begin
                    busy_q           <= 1'b1;
                    reqReady         <= 1'b1;
                    cacheSramSelectN <= 1'b0;
                    cacheSramWriteN  <= !reqWrite;
                    cacheDataOe      <= reqWrite;
                    cacheDataOut     <= reqData;
                    cacheByteParityOut <= oddPar(reqData);
                    lastOp_q <= reqWrite ? `L2SC_OP_WRITE : `L2SC_OP_READ;
                end
                else
                begin
                    busy_q           <= 1'b0;
                    cacheSramSelectN <= 1'b1;
                    cacheSramWriteN  <= 1'b1;
                    cacheDataOe      <= 1'b0;
                    if (reqValid && turnAround && !busy_q)
                    begin
                        // The idle cycle just spent released the bus.
                        lastOp_q <= `L2SC_OP_IDLE;
                    end
                end
            end
        end
    end

endmodule // l2sc_ctrl
`default_nettype wire

// ---- hw/l2sc_defines.vh ----
// Constants for the cache SRAM clock and control block.
// Assumes inclusion by bare name from the design file only.
`ifndef L2SC_DEFINES_VH
`define L2SC_DEFINES_VH
`define L2SC_CLK_DIV_HALF    4'h1
`define L2SC_WAKE_GAP        4'h2
`define L2SC_TURN_GAP        4'h1
`define L2SC_LOCK_WINDOW     4'hC
`define L2SC_SYNC_AGE_MAX    4'hF
`define L2SC_OP_IDLE         2'h0
`define L2SC_OP_READ         2'h1
`define L2SC_OP_WRITE        2'h2
`endif

// ---- test/l2sc_properties.sv ----
// Checker for the cache SRAM select, strobe, clock and sleep outputs.
// Assumes it is bound to l2sc_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module l2sc_properties (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic reqReady,
    input wire logic cfgDiffClock,
    input wire logic cfgSleepEnable,
    input wire logic cacheSramSelectN,
    input wire logic cacheSramWriteN,
    input wire logic cacheClockOutFirst,
    input wire logic cacheClockOutSecond,
    input wire logic cacheSyncClockOut,
    input wire logic sramSleepStrobe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // The reset check may not be disabled by the reset it watches.
    a_reset_idle: assert property (disable iff (1'b0)
        !arst_n |-> cacheSramSelectN && cacheSramWriteN && !sramSleepStrobe
        && !cacheClockOutFirst && !cacheClockOutSecond && !cacheSyncClockOut)
        else $error("outputs not idle in reset");
    a_write_selected: assert property (
        !cacheSramWriteN |-> !cacheSramSelectN) else $error("bare write");
    a_ready_selects: assert property (
        reqReady |-> !cacheSramSelectN) else $error("taken, no select");
    a_select_holds: assert property (
        $fell(cacheSramSelectN) |-> !cacheSramSelectN [*4])
        else $error("select too short");
    a_clock_pair: assert property (
        $past(arst_n) && $stable(cfgDiffClock) |->
        cacheClockOutSecond == (cacheClockOutFirst ^ cfgDiffClock))
        else $error("clock pair wrong");
    a_sync_follows: assert property (
        $past(arst_n) |-> cacheSyncClockOut == cacheClockOutFirst)
        else $error("sync clock wrong");
    a_sleep_gated: assert property (
        !cfgSleepEnable && !$past(cfgSleepEnable) |-> !sramSleepStrobe)
        else $error("sleep not enabled");
    a_wake_gap: assert property (
        $fell(sramSleepStrobe) |-> cacheSramSelectN [*8])
        else $error("access too soon");
    a_asleep_idle: assert property (
        sramSleepStrobe |-> cacheSramSelectN) else $error("access asleep");
endmodule // l2sc_properties
bind l2sc_ctrl l2sc_properties chk (
    .ref_clk             (ref_clk),
    .arst_n              (arst_n),
    .reqReady            (reqReady),
    .cfgDiffClock        (cfgDiffClock),
    .cfgSleepEnable      (cfgSleepEnable),
    .cacheSramSelectN    (cacheSramSelectN),
    .cacheSramWriteN     (cacheSramWriteN),
    .cacheClockOutFirst  (cacheClockOutFirst),
    .cacheClockOutSecond (cacheClockOutSecond),
    .cacheSyncClockOut   (cacheSyncClockOut),
    .sramSleepStrobe     (sramSleepStrobe)
);
`default_nettype wire

// ---- test/l2sc_sram_model.sv ----
// Far side: board trace returning the sync clock to the block.
// Assumes the sync output only changes on the block's clock.
`timescale 1ns/10ps
`default_nettype none
module l2sc_sram_model (
    input  wire logic syncOut,
    output var logic  syncIn
);
    // Trace delay keeps the returned edge away from the sampling edge.
    initial syncIn = 1'b0;
    always @(syncOut) syncIn <= #7 syncOut;
endmodule // l2sc_sram_model
`default_nettype wire

// ---- test/l2_sram_clock_control_tb.sv ----
// Self-checking bench for l2sc_ctrl with the sync loop-back model.
// Assumes a 25 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module l2_sram_clock_control_tb;
    // The clock starts high so reset is driven on the first falling edge,
    // before any rising edge reaches the block with unknown state.
    logic ref_clk = 1'b1, arst_n = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
    logic cfgDiffClock = 1'b0, cfgSleepEnable = 1'b0, powerDown = 1'b0;
    logic [63:0] reqData = 64'h0, cacheDataOut;
    logic [7:0] cacheByteParityOut;
    logic reqReady, cacheSramSelectN, cacheSramWriteN, cacheClockOutFirst;
    logic cacheClockOutSecond, cacheSyncClockOut, sramSleepStrobe;
    logic syncLocked, cacheDataOe;
    wire logic cacheSyncClockIn;
    int error_cnt = 0, n_checks = 0, i, k;
    // Row: write flag, data word, expected odd byte parity.
    logic [72:0] rows [4] = '{{1'b1, 64'h0123456789ABCDEF, 8'h00},
        {1'b0, 64'hFFFFFFFFFFFFFFFF, 8'h00},
        {1'b1, 64'h00FF00FF00FF00FF, 8'hFF},
        {1'b1, 64'h8000000000000001, 8'h7E}};
    l2sc_ctrl dut (
        .ref_clk             (ref_clk),
        .arst_n              (arst_n),
        .reqValid            (reqValid),
        .reqWrite            (reqWrite),
        .reqData             (reqData),
        .reqReady            (reqReady),
        .cfgDiffClock        (cfgDiffClock),
        .cfgSleepEnable      (cfgSleepEnable),
        .powerDown           (powerDown),
        .cacheSyncClockIn    (cacheSyncClockIn),
        .cacheSramSelectN    (cacheSramSelectN),
        .cacheSramWriteN     (cacheSramWriteN),
        .cacheClockOutFirst  (cacheClockOutFirst),
        .cacheClockOutSecond (cacheClockOutSecond),
        .cacheSyncClockOut   (cacheSyncClockOut),
        .sramSleepStrobe     (sramSleepStrobe),
        .syncLocked          (syncLocked),
        .cacheDataOut        (cacheDataOut),
        .cacheByteParityOut  (cacheByteParityOut),
        .cacheDataOe         (cacheDataOe)
    );
    l2sc_sram_model far (
        .syncOut (cacheSyncClockOut),
        .syncIn  (cacheSyncClockIn)
    );
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Holds the request until a falling edge shows it taken, bounded.
    task automatic access(input logic wr, input logic [63:0] d);
        @(negedge ref_clk);
        {reqValid, reqWrite, reqData} = {1'b1, wr, d};
        for (k = 0; reqReady !== 1'b1 && k < 300; k++) @(negedge ref_clk);
        reqValid = 1'b0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #300000 error_cnt++;
        final_report();
    end
    initial
    begin
        @(negedge ref_clk) arst_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            access(rows[i][72], rows[i][71:8]);
            chk("select", 64'(cacheSramSelectN), 64'h0);
            chk("write_n", 64'(cacheSramWriteN), 64'(!rows[i][72]));
            chk("data drive", 64'(cacheDataOe), 64'(rows[i][72]));
            if (rows[i][72])
            begin
                chk("parity", 64'(cacheByteParityOut),
                    64'(rows[i][7:0]));
                chk("write data", cacheDataOut, rows[i][71:8]);
            end
        end
        chk("lock", 64'(syncLocked), 64'h1);
        $display("access rows done");
        repeat (4) @(negedge ref_clk) chk("same clock",
            64'(cacheClockOutSecond), 64'(cacheClockOutFirst));
        cfgDiffClock = 1'b1;
        repeat (3) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk) chk("second clock",
            64'(cacheClockOutSecond), 64'(!cacheClockOutFirst));
        cfgDiffClock = 1'b0;
        powerDown = 1'b1;
        repeat (12) @(negedge ref_clk);
        chk("sleep off", 64'(sramSleepStrobe), 64'h0);
        cfgSleepEnable = 1'b1;
        repeat (12) @(negedge ref_clk);
        chk("sleep on", 64'(sramSleepStrobe), 64'h1);
        powerDown = 1'b0;
        for (k = 0; sramSleepStrobe !== 1'b0 && k < 20; k++) @(negedge ref_clk);
        chk("wake", 64'(sramSleepStrobe), 64'h0);
        access(1'b1, 64'h5A5A5A5A5A5A5A5A);
        chk("wake gap", 64'(k >= 7), 64'h1);
        $display("sleep and clocks done");
        powerDown = 1'b1;
        repeat (12) @(negedge ref_clk);
        arst_n = 1'b0;
        @(negedge ref_clk);
        chk("reset outs",
            64'({cacheSramSelectN, cacheSramWriteN, cacheClockOutFirst,
            cacheClockOutSecond, cacheSyncClockOut, sramSleepStrobe}),
            64'h30);
        chk("lock after reset", 64'(syncLocked), 64'h0);
        powerDown = 1'b0;
        arst_n = 1'b1;
        access(1'b0, 64'h0);
        chk("after reset", 64'(reqReady), 64'h1);
        $display("reset done");
        final_report();
    end
endmodule // l2_sram_clock_control_tb
`default_nettype wire
